// ### hdl/cbpc_pkg.sv
package cbpc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SOCK_CTRL_OFS = 8'h10;
  localparam logic [7:0] PWR_MGMT_OFS  = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h34;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int VPP_LSB        = 0;
  localparam int VCC_LSB        = 4;
  localparam int PERM_BIT       = 7;
  localparam int CTRL_RSVD3_BIT = 3;
  localparam int POL_SEL_BIT    = 0;
  localparam int POL_EN_BIT     = 16;
  localparam int MODE_BIT       = 24;
  localparam int ACCESS_BIT     = 25;
  localparam int EV_ACCESS      = 0;
  localparam int EV_MODE        = 1;
  localparam int EV_W           = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]      VPP_RST  = 3'h0;
  localparam logic [2:0]      VCC_RST  = 3'h0;
  localparam logic [31:0]     REG_RST  = 32'h0000_0000;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // timing: slow mode divides the normal card clock by 16
  // ----------------------------------------------------------------
  localparam int SLOW_FACTOR   = 16;
  localparam int DIV_W         = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = 4'hf;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CBPC_VPP_OFF  = 3'h0,
    CBPC_VPP_12V  = 3'h1,
    CBPC_VPP_5V   = 3'h2,
    CBPC_VPP_3V3  = 3'h3,
    CBPC_VPP_XXV  = 3'h4,
    CBPC_VPP_YYV  = 3'h5,
    CBPC_VPP_RSV6 = 3'h6,
    CBPC_VPP_RSV7 = 3'h7
  } cbpc_vpp_t;

  typedef enum logic [1:0] {
    CBPC_RUN  = 2'h0,
    CBPC_SLOW = 2'h1,
    CBPC_STOP = 2'h2
  } cbpc_clk_state_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// ### hdl/cbpc_sync.sv
`timescale 1ns/1ns
module cbpc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import cbpc_pkg::*;

  // ----------------------------------------------------------------
  // two flops; the first is read only by the second
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_bad_width
    $error("cbpc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ### hdl/cbpc_clkrun.sv
`timescale 1ns/1ns
module cbpc_clkrun (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // conditions
  input  wire logic socket_idle,
  input  wire logic host_stop_prep,
  input  wire logic idle_clock_permission,
  input  wire logic clock_policy_enable,
  input  wire logic clock_policy_select,
  // card clock and mode
  output logic      card_clk,
  output logic      clock_mode_flag,
  output logic      mode_change
);
  import cbpc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cbpc_clk_state_t  state;
  cbpc_clk_state_t  next_state;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             next_card_clk;
  logic             next_mode_flag;
  logic             attempt;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    // without permission the host clock must also be winding down
    attempt = socket_idle && clock_policy_enable &&
              (idle_clock_permission || host_stop_prep);
    next_state    = state;
    next_div_cnt  = div_cnt;
    next_card_clk = card_clk;
    case (state)
      CBPC_RUN: begin
        next_card_clk = !card_clk;
        next_div_cnt  = '0;
        if (attempt && clock_policy_select) begin
          next_state = CBPC_SLOW;
        end else if (attempt && !card_clk) begin
          // stop only after a high phase so no runt pulse leaves
          next_state    = CBPC_STOP;
          next_card_clk = 1'b0;
        end
      end
      CBPC_SLOW: begin
        next_div_cnt = div_cnt + 4'h1;
        if (div_cnt == DIV_LAST) begin
          next_card_clk = !card_clk;
        end
        if (!attempt || !clock_policy_select) begin
          next_state = CBPC_RUN;
        end
      end
      CBPC_STOP: begin
        next_card_clk = 1'b0;
        if (!attempt || clock_policy_select) begin
          next_state = CBPC_RUN;
        end
      end
      default: begin
        next_state    = CBPC_RUN;
        next_card_clk = 1'b0;
        next_div_cnt  = '0;
      end
    endcase
    next_mode_flag = (next_state != CBPC_RUN);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state           <= CBPC_RUN;
      div_cnt         <= '0;
      card_clk        <= 1'b0;
      clock_mode_flag <= 1'b0;
      mode_change     <= 1'b0;
    end else begin
      state           <= next_state;
      div_cnt         <= next_div_cnt;
      card_clk        <= next_card_clk;
      clock_mode_flag <= next_mode_flag;
      mode_change     <= next_mode_flag != clock_mode_flag;
    end
  end

endmodule

// ### hdl/cbpc_socket_ctrl.sv
`timescale 1ns/1ns
//
// Functional notes
// - Socket control bits 31 to 8 read as zero and ignore writes.
// - With permission 0 the card clock is stopped or slowed only when the socket is idle and the host clock is being wound down.
// - With permission 1 the card clock may be stopped or slowed whenever the socket is idle.
// - Programming voltage field bits 2 to 0 codes 0 off, 1 12V, 2 5V, 3 3.3V, 4 X.X, 5 Y.Y, 6-7 reserved, reset 0.
// - Socket control bit 3 always reads zero.
// - Access flag bit 25 sets on a card access and any read of the power register clears it.
// - Mode flag bit 24 reads 1 while the card clock is not running normally.
// - Policy enable bit 16 resets to 0 and gates the policy select bit.
// - When enabled, select 0 stops the card clock in idle and select 1 divides it by 16.
// - Power register bits 31-26, 23-17 and 15-1 read as zero.
// - Power management register sits at offset 20h and resets to zero.
// - Socket control register sits at offset 10h and resets to zero.
//
module cbpc_socket_ctrl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // socket side pins
  input  wire logic        socket_idle,
  input  wire logic        host_stop_prep,
  input  wire logic        card_access,
  // power switch and card clock
  output logic      [2:0]  prog_voltage_request,
  output logic      [2:0]  card_supply_request,
  output logic             card_clk,
  output logic             clock_mode_flag,
  // interrupt
  output logic             irq
);
  import cbpc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a,
                               input logic [7:0]  ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic            [2:0]  vpp;
  logic            [2:0]  next_vpp;
  logic            [2:0]  vcc;
  logic            [2:0]  next_vcc;
  logic                   perm;
  logic                   next_perm;
  logic                   pol_en;
  logic                   next_pol_en;
  logic                   pol_sel;
  logic                   next_pol_sel;
  logic                   access_flag;
  logic                   next_access_flag;
  logic [EV_W-1:0]        ev_stat;
  logic [EV_W-1:0]        next_ev_stat;
  logic [EV_W-1:0]        ev_mask;
  logic [EV_W-1:0]        next_ev_mask;
  logic                   dp_write;
  logic                   next_dp_write;
  logic            [31:0] dp_addr;
  logic            [31:0] next_dp_addr;
  logic            [31:0] next_hrdata;
  logic                   next_irq;
  logic                   ap_valid;
  logic                   ap_read;
  logic                   pin_idle;
  logic                   pin_prep;
  logic                   pin_access;
  logic                   access_prev;
  logic                   access_pulse;
  logic                   mode_flag;
  logic                   mode_change;
  logic                   card_clk_int;
  logic [EV_W-1:0]        events;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  cbpc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({socket_idle, host_stop_prep, card_access}),
    .sync_out ({pin_idle, pin_prep, pin_access})
  );

  // ----------------------------------------------------------------
  // card clock-run engine
  // ----------------------------------------------------------------
  cbpc_clkrun u_clkrun (
    .clk                   (clk),
    .reset_n               (reset_n),
    .socket_idle           (pin_idle),
    .host_stop_prep        (pin_prep),
    .idle_clock_permission (perm),
    .clock_policy_enable   (pol_en),
    .clock_policy_select   (pol_sel),
    .card_clk              (card_clk_int),
    .clock_mode_flag       (mode_flag),
    .mode_change           (mode_change)
  );

  // ----------------------------------------------------------------
  // bus decode and pin events
  // ----------------------------------------------------------------
  always_comb begin
    // zero-wait slave: every valid address phase is taken
    ap_valid     = hsel && hready &&
                   (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    ap_read      = ap_valid && !hwrite;
    access_pulse = pin_access && !access_prev;
    events       = '0;
    events[EV_ACCESS] = access_pulse;
    events[EV_MODE]   = mode_change;

    next_dp_write = ap_valid && hwrite;
    next_dp_addr  = ap_valid ? haddr : dp_addr;
  end

  // ----------------------------------------------------------------
  // control and interrupt register writes
  // ----------------------------------------------------------------
  always_comb begin
    next_vpp      = vpp;
    next_vcc      = vcc;
    next_perm     = perm;
    next_pol_en   = pol_en;
    next_pol_sel  = pol_sel;
    next_ev_mask  = ev_mask;
    next_ev_stat  = ev_stat;

    if (dp_write && hit(dp_addr, SOCK_CTRL_OFS)) begin
      // upper bits and bit 3 have no storage
      next_vpp  = hwdata[VPP_LSB +: 3];
      next_vcc  = hwdata[VCC_LSB +: 3];
      next_perm = hwdata[PERM_BIT];
    end
    if (dp_write && hit(dp_addr, PWR_MGMT_OFS)) begin
      next_pol_en  = hwdata[POL_EN_BIT];
      next_pol_sel = hwdata[POL_SEL_BIT];
    end
    if (dp_write && hit(dp_addr, IRQ_MASK_OFS)) begin
      next_ev_mask = hwdata[EV_W-1:0];
    end
    if (dp_write && hit(dp_addr, IRQ_STAT_OFS)) begin
      next_ev_stat = ev_stat & ~hwdata[EV_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_ev_stat = next_ev_stat | events;
  end

  // ----------------------------------------------------------------
  // socket access flag
  // ----------------------------------------------------------------
  always_comb begin
    // any read of the power register clears; a new access still sets
    next_access_flag = access_flag;
    if (ap_read && hit(haddr, PWR_MGMT_OFS)) begin
      next_access_flag = 1'b0;
    end
    if (access_pulse) begin
      next_access_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    // read data from next values so a write just before is seen
    next_hrdata = REG_RST;
    if (ap_read) begin
      if (hit(haddr, SOCK_CTRL_OFS)) begin
        next_hrdata[VPP_LSB +: 3] = next_vpp;
        next_hrdata[VCC_LSB +: 3] = next_vcc;
        next_hrdata[PERM_BIT]     = next_perm;
        next_hrdata[CTRL_RSVD3_BIT] = 1'b0;
      end else if (hit(haddr, PWR_MGMT_OFS)) begin
        next_hrdata[POL_SEL_BIT] = next_pol_sel;
        next_hrdata[POL_EN_BIT]  = next_pol_en;
        next_hrdata[MODE_BIT]    = mode_flag;
        next_hrdata[ACCESS_BIT]  = access_flag;
      end else if (hit(haddr, IRQ_STAT_OFS)) begin
        next_hrdata[EV_W-1:0] = next_ev_stat;
      end else if (hit(haddr, IRQ_MASK_OFS)) begin
        next_hrdata[EV_W-1:0] = next_ev_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt level
  // ----------------------------------------------------------------
  always_comb begin
    // from next values so the line moves with the status write
    next_irq = |(next_ev_stat & next_ev_mask);
  end

  // ----------------------------------------------------------------
  // bus phase registers
  // ----------------------------------------------------------------
  // hreadyout and hresp are flops too, so every output is registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dp_write  <= 1'b0;
      dp_addr   <= '0;
      hrdata    <= REG_RST;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_write  <= next_dp_write;
      dp_addr   <= next_dp_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vpp     <= VPP_RST;
      vcc     <= VCC_RST;
      perm    <= 1'b0;
      pol_en  <= 1'b0;
      pol_sel <= 1'b0;
    end else begin
      vpp     <= next_vpp;
      vcc     <= next_vcc;
      perm    <= next_perm;
      pol_en  <= next_pol_en;
      pol_sel <= next_pol_sel;
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      access_flag <= 1'b0;
      ev_stat     <= '0;
      ev_mask     <= MASK_RST;
      irq         <= 1'b0;
    end else begin
      access_flag <= next_access_flag;
      ev_stat     <= next_ev_stat;
      ev_mask     <= next_ev_mask;
      irq         <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // access edge detector
  // ----------------------------------------------------------------
  // reset low to match the idle level of the access pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      access_prev <= 1'b0;
    end else begin
      access_prev <= pin_access;
    end
  end

  // ----------------------------------------------------------------
  // socket side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_voltage_request <= VPP_RST;
      card_supply_request  <= VCC_RST;
      card_clk             <= 1'b0;
      clock_mode_flag      <= 1'b0;
    end else begin
      prog_voltage_request <= next_vpp;
      card_supply_request  <= next_vcc;
      // one extra flop of delay on the card clock, same on every edge
      card_clk             <= card_clk_int;
      clock_mode_flag      <= mode_flag;
    end
  end

endmodule

// ### bench/cbpc_socket_ctrl_props.sv
`timescale 1ns/1ns
module cbpc_socket_ctrl_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // socket side
  input wire logic        socket_idle,
  input wire logic [2:0]  prog_voltage_request,
  input wire logic [2:0]  card_supply_request,
  input wire logic        card_clk,
  input wire logic        clock_mode_flag
);
  import cbpc_pkg::*;
  // ----------------------------------------------------------------
  // data phase trackers
  // ----------------------------------------------------------------
  logic take, rd_ctrl, rd_pm, wr_ctrl;
  logic next_rd_ctrl, next_rd_pm, next_wr_ctrl;
  assign take = hsel && hready && htrans[1];
  always_comb begin
    next_rd_ctrl = take && !hwrite && haddr[7:0] == SOCK_CTRL_OFS;
    next_rd_pm   = take && !hwrite && haddr[7:0] == PWR_MGMT_OFS;
    next_wr_ctrl = take && hwrite && haddr[7:0] == SOCK_CTRL_OFS;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ctrl <= 1'b0;
      rd_pm   <= 1'b0;
      wr_ctrl <= 1'b0;
    end else begin
      rd_ctrl <= next_rd_ctrl;
      rd_pm   <= next_rd_pm;
      wr_ctrl <= next_wr_ctrl;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ctrl_hi_zero: assert property (
    rd_ctrl |-> hrdata[31:8] == 24'h0)
    else $error("control upper bits not zero");
  a_ctrl_bit3_zero: assert property (
    rd_ctrl |-> !hrdata[3]) else $error("control bit 3 not zero");
  a_pm_rsvd_zero: assert property (
    rd_pm |-> (hrdata & 32'hfcfe_fffe) == 32'h0)
    else $error("power reserved bits not zero");
  a_req_follow: assert property (
    wr_ctrl |=> prog_voltage_request == $past(hwdata[2:0]) &&
                card_supply_request == $past(hwdata[6:4]))
    else $error("voltage requests do not follow write");
  a_mode_read: assert property (
    rd_pm |-> hrdata[24] == clock_mode_flag)
    else $error("mode bit differs from mode pin");
  a_busy_runs: assert property (
    !socket_idle [*6] |=> card_clk != $past(card_clk))
    else $error("card clock not running while busy");
  a_busy_no_flag: assert property (
    !socket_idle [*8] |=> !clock_mode_flag)
    else $error("mode flag set while busy");
  a_halt_flags: assert property (
    $stable(card_clk) [*4] |-> clock_mode_flag || $past(clock_mode_flag))
    else $error("clock held without mode flag");
endmodule

bind cbpc_socket_ctrl cbpc_socket_ctrl_props u_props (
  .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hrdata, .socket_idle, .prog_voltage_request, .card_supply_request,
  .card_clk, .clock_mode_flag
);

// ### bench/cbpc_card_model.sv
`timescale 1ns/1ns
module cbpc_card_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // requests from the bench
  input  wire logic want_idle,
  input  wire logic want_prep,
  input  wire logic access_go,
  // socket pins
  output logic      socket_idle,
  output logic      host_stop_prep,
  output logic      card_access
);
  // ----------------------------------------------------------------
  // access strobe
  // ----------------------------------------------------------------
  // held four cycles so the two-flop synchroniser cannot miss it
  logic [2:0] hold;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 3'h0;
    end else if (access_go) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign card_access    = hold != 3'h0;
  assign socket_idle    = want_idle;
  assign host_stop_prep = want_prep;
endmodule

// ### bench/tb_cbpc_socket_ctrl.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  n_fail++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_cbpc_socket_ctrl;
  import cbpc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, reset_n, hsel, hwrite, want_idle, want_prep, access_go;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, prog_voltage_request, card_supply_request;
  logic        hreadyout, hresp, card_clk, clock_mode_flag, irq;
  wire  logic  hready, socket_idle, host_stop_prep, card_access;
  int          n_fail, num_checks, cyc;
  assign hready = hreadyout;
  cbpc_socket_ctrl dut (
    .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .socket_idle, .host_stop_prep,
    .card_access, .prog_voltage_request, .card_supply_request, .card_clk,
    .clock_mode_flag, .irq);
  cbpc_card_model u_card (
    .clk, .reset_n, .want_idle, .want_prep, .access_go, .socket_idle,
    .host_stop_prep, .card_access);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic ahb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, a, d, q);
  endtask
  task automatic rdr(input logic [7:0] a);
    ahb_xfer(1'b0, a, 32'h0, rd);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdr(SOCK_CTRL_OFS); `CHK("ctrl reset", 32'h0, rd)
    rdr(PWR_MGMT_OFS); `CHK("pm reset", 32'h0, rd)
    rdr(IRQ_MASK_OFS); `CHK("mask reset", 32'h0, rd)
    wr(8'h40, 32'hffff_ffff);
    rdr(8'h40); `CHK("unmapped", 32'h0, rd)
    $display("test regs done");
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 8; i++) begin
      wr(SOCK_CTRL_OFS, {24'hff_ffff, 1'b1, i[2:0], 1'b1, i[2:0]});
      rdr(SOCK_CTRL_OFS);
      `CHK("ctrl", {24'h0, 1'b1, i[2:0], 1'b0, i[2:0]}, rd)
      `CHK("vpp pins", i[2:0], prog_voltage_request)
      `CHK("vcc pins", i[2:0], card_supply_request)
    end
    $display("test ctrl done");
  endtask
  task automatic t_pm;
    wr(PWR_MGMT_OFS, 32'hffff_ffff);
    rdr(PWR_MGMT_OFS); `CHK("pm", 32'h0001_0001, rd)
    wr(PWR_MGMT_OFS, 32'h0);
    $display("test pm done");
  endtask
  task automatic t_access;
    access_go <= 1'b1;
    @(posedge clk);
    access_go <= 1'b0;
    wait_cyc(8);
    `CHK("irq masked", 1'b0, irq)
    rdr(PWR_MGMT_OFS); `CHK("access set", 1'b1, rd[ACCESS_BIT])
    rdr(PWR_MGMT_OFS); `CHK("access clr", 1'b0, rd[ACCESS_BIT])
    wr(IRQ_MASK_OFS, 32'h1);
    wait_cyc(2); `CHK("irq on", 1'b1, irq)
    wr(IRQ_STAT_OFS, 32'h1);
    wait_cyc(2); `CHK("irq off", 1'b0, irq)
    $display("test access done");
  endtask
  // count card clock rises over a window long enough for the slow mode
  task automatic clk_case(input logic en, sel, perm, prep, idle,
                          input logic [7:0] ex);
    logic       prev;
    logic [7:0] rises;
    wr(SOCK_CTRL_OFS, {24'h0, perm, 7'h0});
    wr(PWR_MGMT_OFS, {15'h0, en, 15'h0, sel});
    want_idle <= idle;
    want_prep <= prep;
    wait_cyc(40);
    rises = 8'h0;
    prev = card_clk;
    repeat (64) begin
      @(posedge clk);
      if (card_clk && !prev) rises++;
      prev = card_clk;
    end
    `CHK("clk rises", ex, rises)
    `CHK("mode flag", ex != 8'd32, clock_mode_flag)
    rdr(PWR_MGMT_OFS); `CHK("mode bit", ex != 8'd32, rd[MODE_BIT])
  endtask
  task automatic t_clock;
    wr(IRQ_MASK_OFS, 32'h0);
    clk_case(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'd32);
    clk_case(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'd2);
    clk_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'd0);
    clk_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'd32);
    clk_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'd0);
    clk_case(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'd32);
    rdr(IRQ_STAT_OFS); `CHK("mode event", 1'b1, rd[EV_MODE])
    wr(IRQ_MASK_OFS, 32'h2);
    wait_cyc(2); `CHK("irq mode", 1'b1, irq)
    $display("test clock done");
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // a hung wait would otherwise stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    reset_n = 1'b0;
    {hsel, hwrite, want_idle, want_prep, access_go} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_ctrl();
    t_pm();
    t_access();
    t_clock();
    wrap_up();
  end
endmodule
